// ==== logic/bsm_merit.sv ====
// Backup server eligibility checks and merit score engine
`timescale 1ns/1ps
`include "bsm_regs.svh"
// Function
// - Headroom configurable, defaults to 6 dB
// - Downstream target level defaults to 0 dBmV
// - Downstream upper limit defaults to +5 dBmV
// - Downstream lower limit defaults to -6 dBmV
// - Ratio span defaults 80 dB, divides equalizer
// - Tap ceiling defaults to -5 dB
// - Compression floor defaults to -2
// - Modulation maximum 58/55/54 dBmV, all configurable
// - Any enabled failing check clears eligibility
// - Upstream passes if level below max minus headroom
// - Downstream passes within limits, bounds inclusive
// - Equalizer passes if compression above floor
// - Any tap above ceiling clears eligibility
// - Score sums upstream, downstream, equalizer terms
// - Upstream term is weight times one minus ratio
// - Zero upstream weight drops term and check
// - Downstream term uses normalised absolute offset
// - Zero downstream weight drops term and check
// - Equalizer term is minus ratio over span weighted
// - Zero equalizer weight drops term, compression check
// - Any parameter or weight change re-evaluates
// - No advertising while not eligible
module bsm_merit (
   input  wire logic               ref_clk,
   input  wire logic               resetn,
   input  wire logic               ce,
   input  wire logic               wb_cyc,
   input  wire logic               wb_stb,
   input  wire logic               wb_we,
   input  wire logic [7:0]         wb_adr,
   input  wire logic [3:0]         wb_sel,
   input  wire logic [31:0]        wb_dat_w,
   output logic      [31:0]        wb_dat_r,
   output logic                    wb_ack,
   input  wire logic               meas_valid,
   input  wire bsm_pkg::bsm_meas_t meas,
   output logic                    eligible,
   output logic                    adv_enable,
   output logic                    score_valid,
   output logic      [31:0]        merit_score
);
   import bsm_pkg::*;

   // Byte-lane merge for a 16-bit field
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  sel);
      merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction

   // Magnitude of a signed 17-bit value
   function automatic logic [16:0] mag17(input logic [16:0] x);
      mag17 = x[16] ? 17'(-x) : x;
   endfunction

   // Configuration, engine state, check results and divider operands
   logic [15:0] headroom, ds_target_level, ds_upper_limit, ds_lower_limit;
   logic [15:0] nonmain_ratio_span, nonmain_tap_ceiling, main_tap_floor;
   logic [15:0] max_qpsk, max_qam16, max_qam64, mod_max, base_us, base_ds;
   logic [7:0]  us_weight, ds_weight, equalizer_weight, tap_over, w_in;
   logic        adv_allow, pending, has_result, ck_us, ck_ds, ck_eq, ck_tap;
   logic        neg_us, neg_eq, req, wr, go, us_pass, ds_pass, eq_pass;
   bsm_meas_t   meas_q;
   bsm_state_t  state;
   logic [1:0]  phase;
   logic [4:0]  step;
   logic [16:0] den_us, den_ds, den_eq, den, us_limit, ds_offset, ds_range;
   logic [17:0] rem, shifted;
   logic [31:0] num_us, num_ds, num_eq, quo, acc, rd_data;
   logic [31:0] quo_used, signed_q, term;

   assign req = wb_cyc & wb_stb & ~wb_ack;
   assign wr  = req & wb_we;
   // Any register write may change a parameter or weight
   assign go  = meas_valid | wr;
   assign w_in = (wb_dat_w[7:0] > `BSM_WEIGHT_MAX) ? `BSM_WEIGHT_MAX : wb_dat_w[7:0];

   // Bus handshake, one wait cycle per access
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         wb_ack   <= 1'b0;
         wb_dat_r <= 32'h0000_0000;
      end else if (ce) begin
         wb_ack   <= req;
         wb_dat_r <= req ? rd_data : 32'h0000_0000;
      end
   end

   // Configuration registers with their default values
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         headroom            <= `BSM_RST_HEADROOM;
         ds_target_level     <= `BSM_RST_DS_TARGET;
         ds_upper_limit      <= `BSM_RST_DS_UPPER;
         ds_lower_limit      <= `BSM_RST_DS_LOWER;
         nonmain_ratio_span  <= `BSM_RST_SPAN;
         nonmain_tap_ceiling <= `BSM_RST_CEILING;
         main_tap_floor      <= `BSM_RST_FLOOR;
         max_qpsk            <= `BSM_RST_MAX_QPSK;
         max_qam16           <= `BSM_RST_MAX_QAM16;
         max_qam64           <= `BSM_RST_MAX_QAM64;
         us_weight           <= `BSM_RST_WEIGHT;
         ds_weight           <= `BSM_RST_WEIGHT;
         equalizer_weight    <= `BSM_RST_WEIGHT;
         adv_allow           <= 1'b1;
      end else if (ce && wr) begin
         case (wb_adr)
            `BSM_OFS_CTRL: begin
               if (wb_sel[0]) begin
                  adv_allow <= wb_dat_w[`BSM_CTRL_ADV_ALLOW];
               end
            end
            `BSM_OFS_HEADROOM: begin
               headroom <= merge16(headroom, wb_dat_w, wb_sel);
            end
            `BSM_OFS_DS_TARGET: begin
               ds_target_level <= merge16(ds_target_level, wb_dat_w, wb_sel);
            end
            `BSM_OFS_DS_UPPER: begin
               ds_upper_limit <= merge16(ds_upper_limit, wb_dat_w, wb_sel);
            end
            `BSM_OFS_DS_LOWER: begin
               ds_lower_limit <= merge16(ds_lower_limit, wb_dat_w, wb_sel);
            end
            `BSM_OFS_SPAN: begin
               nonmain_ratio_span <= merge16(nonmain_ratio_span, wb_dat_w, wb_sel);
            end
            `BSM_OFS_CEILING: begin
               nonmain_tap_ceiling <= merge16(nonmain_tap_ceiling, wb_dat_w, wb_sel);
            end
            `BSM_OFS_FLOOR: begin
               main_tap_floor <= merge16(main_tap_floor, wb_dat_w, wb_sel);
            end
            `BSM_OFS_MAX_QPSK: begin
               max_qpsk <= merge16(max_qpsk, wb_dat_w, wb_sel);
            end
            `BSM_OFS_MAX_QAM16: begin
               max_qam16 <= merge16(max_qam16, wb_dat_w, wb_sel);
            end
            `BSM_OFS_MAX_QAM64: begin
               max_qam64 <= merge16(max_qam64, wb_dat_w, wb_sel);
            end
            // Weights saturate at 100
            `BSM_OFS_W_US: begin
               if (wb_sel[0]) begin
                  us_weight <= w_in;
               end
            end
            `BSM_OFS_W_DS: begin
               if (wb_sel[0]) begin
                  ds_weight <= w_in;
               end
            end
            `BSM_OFS_W_EQ: begin
               if (wb_sel[0]) begin
                  equalizer_weight <= w_in;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Read multiplexer, unmapped words read zero
   always_comb begin
      rd_data = 32'h0000_0000;
      case (wb_adr)
         `BSM_OFS_CTRL:      rd_data[`BSM_CTRL_ADV_ALLOW] = adv_allow;
         `BSM_OFS_HEADROOM:  rd_data[15:0] = headroom;
         `BSM_OFS_DS_TARGET: rd_data[15:0] = ds_target_level;
         `BSM_OFS_DS_UPPER:  rd_data[15:0] = ds_upper_limit;
         `BSM_OFS_DS_LOWER:  rd_data[15:0] = ds_lower_limit;
         `BSM_OFS_SPAN:      rd_data[15:0] = nonmain_ratio_span;
         `BSM_OFS_CEILING:   rd_data[15:0] = nonmain_tap_ceiling;
         `BSM_OFS_FLOOR:     rd_data[15:0] = main_tap_floor;
         `BSM_OFS_MAX_QPSK:  rd_data[15:0] = max_qpsk;
         `BSM_OFS_MAX_QAM16: rd_data[15:0] = max_qam16;
         `BSM_OFS_MAX_QAM64: rd_data[15:0] = max_qam64;
         `BSM_OFS_W_US:      rd_data[7:0]  = us_weight;
         `BSM_OFS_W_DS:      rd_data[7:0]  = ds_weight;
         `BSM_OFS_W_EQ:      rd_data[7:0]  = equalizer_weight;
         `BSM_OFS_STATUS: begin
            rd_data[`BSM_ST_ELIGIBLE] = eligible;
            rd_data[`BSM_ST_US_OK]    = ck_us;
            rd_data[`BSM_ST_DS_OK]    = ck_ds;
            rd_data[`BSM_ST_EQ_OK]    = ck_eq;
            rd_data[`BSM_ST_TAP_OK]   = ck_tap;
            rd_data[`BSM_ST_BUSY]     = (state != ST_IDLE) | pending;
            rd_data[`BSM_ST_VALID]    = has_result;
         end
         `BSM_OFS_SCORE:     rd_data = merit_score;
         default:            rd_data = 32'h0000_0000;
      endcase
   end

   // Latest measurement set
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         meas_q <= '0;
      end else if (ce && meas_valid) begin
         meas_q <= meas;
      end
   end

   // Maximum level for the active modulation
   always_comb begin
      case (meas_q.modulation)
         MOD_QPSK:  mod_max = max_qpsk;
         MOD_QAM16: mod_max = max_qam16;
         default:   mod_max = max_qam64;
      endcase
   end

   // Minimum link checks on the signed levels
   always_comb begin
      us_limit  = 17'($signed(mod_max)) - 17'($signed(headroom));
      us_pass   = $signed(17'($signed(meas_q.us_tx_level))) < $signed(us_limit);
      ds_pass   = ($signed(ds_lower_limit) <= $signed(meas_q.ds_rx_level)) &&
                  ($signed(meas_q.ds_rx_level) <= $signed(ds_upper_limit));
      eq_pass   = $signed(meas_q.main_tap_squeeze) > $signed(main_tap_floor);
      ds_offset = 17'($signed(meas_q.ds_rx_level)) - 17'($signed(ds_target_level));
      ds_range  = 17'($signed(ds_upper_limit)) - 17'($signed(ds_lower_limit));
   end

   // One comparator per non-main tap
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_tap
         assign tap_over[gi] = $signed(meas_q.nonmain_tap_level[gi]) >
                               $signed(nonmain_tap_ceiling);
      end
   endgenerate

   // Pending request, set wins over the clear at start
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pending <= 1'b0;
      end else if (ce) begin
         if (go) begin
            pending <= 1'b1;
         end else if (state == ST_IDLE) begin
            pending <= 1'b0;
         end
      end
   end

   // Snapshot of checks and divider operands at start
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ck_us   <= 1'b0;
         ck_ds   <= 1'b0;
         ck_eq   <= 1'b0;
         ck_tap  <= 1'b0;
         num_us  <= 32'h0000_0000;
         num_ds  <= 32'h0000_0000;
         num_eq  <= 32'h0000_0000;
         den_us  <= 17'h0_0000;
         den_ds  <= 17'h0_0000;
         den_eq  <= 17'h0_0000;
         neg_us  <= 1'b0;
         neg_eq  <= 1'b0;
         base_us <= 16'h0000;
         base_ds <= 16'h0000;
      end else if (ce && state == ST_IDLE && pending) begin
         ck_us   <= (us_weight == 8'h00) | us_pass;
         ck_ds   <= (ds_weight == 8'h00) | ds_pass;
         ck_eq   <= (equalizer_weight == 8'h00) | eq_pass;
         ck_tap  <= ~|tap_over;
         // Weight times magnitude, eight fraction bits
         num_us  <= {16'h0000, us_weight, 8'h00} *
                    {15'h0000, mag17(17'($signed(meas_q.us_tx_level)))};
         num_ds  <= {16'h0000, ds_weight, 8'h00} * {15'h0000, mag17(ds_offset)};
         num_eq  <= {16'h0000, equalizer_weight, 8'h00} *
                    {15'h0000, mag17(17'($signed(meas_q.nonmain_energy_ratio)))};
         den_us  <= mag17(17'($signed(mod_max)));
         den_ds  <= mag17(ds_range);
         den_eq  <= mag17(17'($signed(nonmain_ratio_span)));
         neg_us  <= meas_q.us_tx_level[15] ^ mod_max[15];
         neg_eq  <= meas_q.nonmain_energy_ratio[15] ^ nonmain_ratio_span[15];
         base_us <= {us_weight, 8'h00};
         base_ds <= {ds_weight, 8'h00};
      end
   end

   // Divider step and term formation
   always_comb begin
      shifted  = {rem[16:0], quo[31]};
      quo_used = (den == 17'h0_0000) ? 32'h0000_0000 : quo;
      signed_q = 32'(-$signed(quo_used));
      case (phase)
         2'b00:   term = {16'h0000, base_us} - (neg_us ? signed_q : quo_used);
         2'b01:   term = {16'h0000, base_ds} - quo_used;
         default: term = neg_eq ? quo_used : signed_q;
      endcase
   end

   // Engine sequence: three terms through one shared divider
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state <= ST_IDLE;
         phase <= 2'b00;
         step  <= 5'h00;
         rem   <= 18'h0_0000;
         quo   <= 32'h0000_0000;
         den   <= 17'h0_0000;
         acc   <= 32'h0000_0000;
      end else if (ce) begin
         case (state)
            ST_IDLE: begin
               phase <= 2'b00;
               acc   <= 32'h0000_0000;
               if (pending) begin
                  state <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               rem  <= 18'h0_0000;
               step <= 5'h00;
               case (phase)
                  2'b00: begin
                     quo <= num_us;
                     den <= den_us;
                  end
                  2'b01: begin
                     quo <= num_ds;
                     den <= den_ds;
                  end
                  default: begin
                     quo <= num_eq;
                     den <= den_eq;
                  end
               endcase
               state <= ST_DIV;
            end
            ST_DIV: begin
               if (shifted >= {1'b0, den}) begin
                  rem <= shifted - {1'b0, den};
                  quo <= {quo[30:0], 1'b1};
               end else begin
                  rem <= shifted;
                  quo <= {quo[30:0], 1'b0};
               end
               step <= step + 5'h01;
               if (step == `BSM_DIV_STEPS) begin
                  state <= ST_ACC;
               end
            end
            ST_ACC: begin
               acc <= acc + term;
               if (phase == 2'b10) begin
                  state <= ST_IDLE;
               end else begin
                  phase <= phase + 2'b01;
                  state <= ST_SETUP;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Result publication at the end of the last term
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         eligible    <= 1'b0;
         merit_score <= 32'h0000_0000;
         score_valid <= 1'b0;
         has_result  <= 1'b0;
      end else if (ce) begin
         score_valid <= 1'b0;
         if (state == ST_ACC && phase == 2'b10) begin
            eligible    <= ck_us & ck_ds & ck_eq & ck_tap;
            merit_score <= acc + term;
            score_valid <= 1'b1;
            has_result  <= 1'b1;
         end
      end
   end

   // Advertising permitted only while eligible
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         adv_enable <= 1'b0;
      end else if (ce) begin
         adv_enable <= eligible & adv_allow;
      end
   end

endmodule

// ==== logic/bsm_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef BSM_REGS_SVH
`define BSM_REGS_SVH

// Byte offsets of the 32-bit register words
`define BSM_OFS_CTRL      8'h00
`define BSM_OFS_HEADROOM  8'h04
`define BSM_OFS_DS_TARGET 8'h08
`define BSM_OFS_DS_UPPER  8'h0c
`define BSM_OFS_DS_LOWER  8'h10
`define BSM_OFS_SPAN      8'h14
`define BSM_OFS_CEILING   8'h18
`define BSM_OFS_FLOOR     8'h1c
`define BSM_OFS_MAX_QPSK  8'h20
`define BSM_OFS_MAX_QAM16 8'h24
`define BSM_OFS_MAX_QAM64 8'h28
`define BSM_OFS_W_US      8'h2c
`define BSM_OFS_W_DS      8'h30
`define BSM_OFS_W_EQ      8'h34
`define BSM_OFS_STATUS    8'h38
`define BSM_OFS_SCORE     8'h3c

// Control and status bit positions
`define BSM_CTRL_ADV_ALLOW 0
`define BSM_ST_ELIGIBLE    0
`define BSM_ST_US_OK       1
`define BSM_ST_DS_OK       2
`define BSM_ST_EQ_OK       3
`define BSM_ST_TAP_OK      4
`define BSM_ST_BUSY        5
`define BSM_ST_VALID       6

// Reset values, levels in signed Q12.4 (1/16 dB)
`define BSM_RST_HEADROOM  16'h0060
`define BSM_RST_DS_TARGET 16'h0000
`define BSM_RST_DS_UPPER  16'h0050
`define BSM_RST_DS_LOWER  16'hffa0
`define BSM_RST_SPAN      16'h0500
`define BSM_RST_CEILING   16'hffb0
`define BSM_RST_FLOOR     16'hffe0
`define BSM_RST_MAX_QPSK  16'h03a0
`define BSM_RST_MAX_QAM16 16'h0370
`define BSM_RST_MAX_QAM64 16'h0360
`define BSM_RST_WEIGHT    8'h64
`define BSM_WEIGHT_MAX    8'h64

// Last divider step index per score term, 32 steps
`define BSM_DIV_STEPS     5'h1f

`endif

// ==== logic/bsm_pkg.sv ====
// Types shared by the merit score engine and its users
package bsm_pkg;

   // Active upstream modulation
   typedef enum logic [1:0] {
      MOD_QPSK  = 2'b00,
      MOD_QAM16 = 2'b01,
      MOD_QAM64 = 2'b10
   } bsm_mod_t;

   // Engine sequencing
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SETUP = 2'b01,
      ST_DIV   = 2'b10,
      ST_ACC   = 2'b11
   } bsm_state_t;

   // One measurement set, levels signed Q12.4
   typedef struct packed {
      logic [7:0][15:0] nonmain_tap_level;
      logic [15:0]      us_tx_level;
      logic [15:0]      ds_rx_level;
      logic [15:0]      nonmain_energy_ratio;
      logic [15:0]      main_tap_squeeze;
      bsm_mod_t         modulation;
   } bsm_meas_t;

endpackage

// ==== bench/bsm_merit_assertions.sv ====
// Checker for bus handshake, result timing and advertising gate
`timescale 1ns/1ps
module bsm_merit_assertions (
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic        ce,
   input wire logic        wb_cyc,
   input wire logic        wb_stb,
   input wire logic [31:0] wb_dat_r,
   input wire logic        wb_ack,
   input wire logic        meas_valid,
   input wire logic        eligible,
   input wire logic        adv_enable,
   input wire logic        score_valid,
   input wire logic [31:0] merit_score
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // Bus answer timing and idle read data
   a_ack_next: assert property (ce && wb_cyc && wb_stb && !wb_ack |=> wb_ack)
      else $error("ack missing one cycle after request");
   a_ack_single: assert property (wb_ack && ce |=> !wb_ack)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property ($rose(wb_ack) |-> $past(wb_cyc && wb_stb))
      else $error("ack without request");
   a_rdata_idle: assert property (!wb_ack |-> wb_dat_r == 32'h0000_0000)
      else $error("read data not zero outside ack");

   // Result timing after a measurement strobe
   a_result_bound: assert property (meas_valid && ce |-> ##[1:230] score_valid)
      else $error("no result after measurement");
   a_valid_pulse: assert property (score_valid && ce |=> !score_valid [*8])
      else $error("result strobe not a single pulse");
   a_result_held: assert property ($changed(eligible) || $changed(merit_score) |-> score_valid)
      else $error("result changed without strobe");

   // Advertising only follows eligibility
   a_adv_gate: assert property (!eligible && ce |=> !adv_enable)
      else $error("advertising while ineligible");
   a_adv_lag: assert property ($rose(adv_enable) |-> $past(eligible))
      else $error("advertising rose without eligibility");
endmodule

// ==== bench/bsm_merit_tb.sv ====
// Self-checking bench for the merit score engine
`timescale 1ns/1ps
`include "bsm_regs.svh"
module bsm_merit_tb;
   import bsm_pkg::*;
   logic        ref_clk     = 1'b0;
   logic        resetn      = 1'b0;
   logic        ce          = 1'b1;
   logic        wb_cyc      = 1'b0;
   logic        wb_stb      = 1'b0;
   logic        wb_we       = 1'b0;
   logic [7:0]  wb_adr      = 8'h00;
   logic [3:0]  wb_sel      = 4'h0;
   logic [31:0] wb_dat_w    = 32'h0;
   logic [31:0] wb_dat_r;
   logic        wb_ack;
   logic        meas_valid  = 1'b0;
   bsm_meas_t   meas        = '0;
   logic        eligible;
   logic        adv_enable;
   logic        score_valid;
   logic [31:0] merit_score;
   int          n_errors    = 0;
   int          check_count = 0;
   int          seed        = 70818;
   int          cfg [14];
   int          it, t, r, mx, k5, k;
   logic [31:0] rv;
   bsm_meas_t   m;

   bsm_merit dut (.ref_clk, .resetn, .ce, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel,
      .wb_dat_w, .wb_dat_r, .wb_ack, .meas_valid, .meas, .eligible, .adv_enable,
      .score_valid, .merit_score);

   // Clock at 25 MHz
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic results();
      if (n_errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask

   // Classic single Wishbone cycle, held until ack is sampled high at a rising edge
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int   i;
      logic ok;
      ok = 1'b0;
      q  = 32'h0;
      @(posedge ref_clk);
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_we    <= we;
      wb_adr   <= a;
      wb_sel   <= 4'hf;
      wb_dat_w <= d;
      for (i = 0; i < 20 && !ok; i++) begin
         @(posedge ref_clk);
         if (wb_ack === 1'b1) begin
            ok = 1'b1;
            q  = wb_dat_r;
         end
      end
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (!ok) begin
         cmp("ack", 1, 0);
         results();
      end
   endtask

   // Register write mirrored in the model, weights clamp at 100
   task automatic wcfg(input int i, input int v);
      bus(1'b1, 8'(i * 4), 32'(v), rv);
      cfg[i] = (i > 10 && v > 100) ? 100 : v;
   endtask

   task automatic rdall();
      for (k = 0; k < 14; k++) begin
         bus(1'b0, 8'(k * 4), 32'h0, rv);
         cmp("reg", cfg[k] & 32'hffff, rv);
      end
   endtask

   function automatic int sx(input logic [15:0] v);
      return int'($signed(v));
   endfunction

   // Reference checks (bit 0 overall, 1 us, 2 ds, 3 eq, 4 taps) and score
   task automatic model(output logic [4:0] ok, output int sc);
      int mxl, tx, rx, dv, i;
      mxl = cfg[8 + (m.modulation > 2 ? 2 : m.modulation)];
      tx = sx(m.us_tx_level);
      rx = sx(m.ds_rx_level);
      dv = cfg[3] - cfg[4];
      dv = dv < 0 ? -dv : dv;
      ok = 5'h1f;
      sc = 0;
      if (cfg[11] != 0) begin
         ok[1] = tx < mxl - cfg[1];
         sc += cfg[11] * 256 - (mxl == 0 ? 0 : cfg[11] * 256 * tx / mxl);
      end
      if (cfg[12] != 0) begin
         ok[2] = rx >= cfg[4] && rx <= cfg[3];
         rx = rx - cfg[2];
         sc += cfg[12] * 256 - (dv == 0 ? 0 : cfg[12] * 256 * (rx < 0 ? -rx : rx) / dv);
      end
      if (cfg[13] != 0) begin
         ok[3] = sx(m.main_tap_squeeze) > cfg[7];
         sc -= cfg[5] == 0 ? 0 : cfg[13] * 256 * sx(m.nonmain_energy_ratio) / cfg[5];
      end
      for (i = 0; i < 8; i++) begin
         ok[4] &= sx(m.nonmain_tap_level[i]) <= cfg[6];
      end
      ok[0] = &ok[4:1];
   endtask

   task automatic chk();
      logic [4:0] ok;
      int         sc;
      model(ok, sc);
      cmp("eligible", ok[0], eligible);
      cmp("score", sc, merit_score);
      @(posedge ref_clk);
      @(negedge ref_clk);
      cmp("adv", ok[0] & cfg[0][0], adv_enable);
      bus(1'b0, `BSM_OFS_SCORE, 32'h0, rv);
      cmp("score_reg", sc, rv);
      // Status word: idle, result present, per-check outcomes
      bus(1'b0, `BSM_OFS_STATUS, 32'h0, rv);
      cmp("status", {25'h0, 2'b10, ok}, rv);
   endtask

   // Measurement strobe, optional clock-enable stall, latency count
   task automatic eval(input bit st);
      int n;
      @(posedge ref_clk);
      meas       <= m;
      meas_valid <= 1'b1;
      for (n = 0; n < 400; n++) begin
         @(negedge ref_clk);
         if (score_valid === 1'b1) break;
         @(posedge ref_clk);
         meas_valid <= 1'b0;
         ce         <= !(st && n < 10);
      end
      cmp("latency", 104 + (st ? 10 : 0), n);
      if (n == 400) begin
         results();
      end else begin
         chk();
      end
   endtask

   // Wait until no result strobe has come for a full rerun
   task automatic settle();
      int q, n;
      q = 0;
      for (n = 0; n < 3000 && q < 230; n++) begin
         @(negedge ref_clk);
         q = (score_valid === 1'b1) ? 0 : q + 1;
      end
      if (q < 230) begin
         cmp("settle", 1, 0);
         results();
      end
   endtask

   // Main sequence: defaults, then boundary cases with random config
   initial begin
      cfg = '{1, 96, 0, 80, -96, 1280, -80, -32, 928, 880, 864, 100, 100, 100};
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      @(negedge ref_clk);
      cmp("elig_rst", 0, eligible);
      cmp("score_rst", 0, merit_score);
      cmp("adv_rst", 0, adv_enable);
      rdall();
      bus(1'b0, 8'h40, 32'h0, rv);
      cmp("unmapped", 0, rv);
      for (it = 0; it < 15; it++) begin
         k5 = it % 5;
         mx = cfg[8 + (it % 4 > 2 ? 2 : it % 4)];
         m.modulation = bsm_mod_t'(2'(it % 4));
         m.us_tx_level = 16'(mx - cfg[1] - (k5 == 1 ? 0 : 1));
         m.ds_rx_level = 16'((it & 1 ? cfg[4] : cfg[3]) + (k5 == 2 ? (it & 1 ? -1 : 1) : 0));
         m.main_tap_squeeze = 16'(cfg[7] + (k5 == 3 ? 0 : 1));
         m.nonmain_energy_ratio = 16'($random(seed) % 3000);
         for (t = 0; t < 8; t++) begin
            m.nonmain_tap_level[t] = 16'(cfg[6] - ($random(seed) & 7));
         end
         m.nonmain_tap_level[it % 8] = 16'(cfg[6] + (k5 == 4));
         eval(it == 2);
         wcfg(0, it % 3 != 0);
         wcfg(1, $random(seed) & 'hff);
         wcfg(2, $random(seed) % 64);
         wcfg(3, 40 + ($random(seed) & 'h7f));
         wcfg(4, -40 - ($random(seed) & 'h7f));
         wcfg(5, it == 3 ? 0 : 1 + ($random(seed) & 'h7ff));
         wcfg(6, $random(seed) % 100);
         wcfg(7, $random(seed) % 100);
         for (t = 8; t < 14; t++) begin
            r = $random(seed);
            wcfg(t, t < 11 ? 600 + (r & 'h1ff) : r[1:0] == 0 ? 0 : r[1:0] == 1 ? 150 : r[8:2]);
         end
         settle();
         chk();
         rdall();
      end
      results();
   end
endmodule

bind bsm_merit bsm_merit_assertions u_chk (.ref_clk, .resetn, .ce, .wb_cyc, .wb_stb,
   .wb_dat_r, .wb_ack, .meas_valid, .eligible, .adv_enable, .score_valid, .merit_score);
